/* File: dcf_defs.svh */
// constants shared by the dual-port flagged fifo
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

// storage geometry
`define DCF_DEPTH        4096
`define DCF_WIDTH        18
`define DCF_OFS_W        12
`define DCF_STAGE_DEPTH  8

// offset register reset value, both offsets
`define DCF_OFS_DEFAULT  12'h07f

// synchroniser bit positions of the pin group
`define DCF_SYNC_BITS    4
`define DCF_SYNC_RESET   0
`define DCF_SYNC_FIRST   1
`define DCF_SYNC_WCHAIN  2
`define DCF_SYNC_RCHAIN  3

`endif

/* File: dcf_far_end.sv */
// consumer-side view of the three-state data lines
`timescale 1ns/100ps
module dcf_far_end #(
   parameter int WIDTH = 18
) (
   input  wire logic             core_clk_i,
   input  wire logic [WIDTH-1:0] q_i,
   input  wire logic             oe_i,
   output logic      [WIDTH-1:0] bus_q_o
);
   logic [WIDTH-1:0] last = '0;
   always_ff @(posedge core_clk_i) begin
      last <= oe_i ? q_i : ~last;
   end
   assign bus_q_o = oe_i ? q_i : ~last;
endmodule

/* File: dcf_fifo_assertions.sv */
// port-level checks of the flagged fifo
`timescale 1ns/100ps
module dcf_fifo_assertions #(
   parameter int WIDTH = 18
) (
   input wire logic                core_clk_i,
   input wire logic                rst_i,
   input wire logic                fifo_reset_n_i,
   input wire logic                write_tick_i,
   input wire logic                read_tick_i,
   input wire logic                read_enable_n_i,
   input wire logic                output_enable_n_i,
   input wire logic                almost_async_i,
   input wire logic [WIDTH-1:0]    read_data_o,
   input wire logic                read_data_oe_o,
   input wire dcf_pkg::dcf_flags_t flags_o,
   input wire logic                fall_through_mode_o
);
   logic [2:0] run;
   logic       ok;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // ok once the device reset pin has long been released
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i || !fifo_reset_n_i) begin
         run <= 3'h0;
      end else if (run != 3'h7) begin
         run <= run + 3'h1;
      end
   end
   assign ok = (run == 3'h7) && fifo_reset_n_i;
   AST_RESET_STATE:
      assert property (!fifo_reset_n_i [*4] |=> read_data_o == '0 && flags_o.half_full_n
         && flags_o.full_ready_n == !fall_through_mode_o && !flags_o.almost_empty_n
         && flags_o.empty_ready_n == fall_through_mode_o && flags_o.almost_full_n)
      else $error("reset flag levels wrong");
   AST_OE_FOLLOWS:
      assert property (ok && $stable(output_enable_n_i) |-> read_data_oe_o == !output_enable_n_i)
      else $error("output enable not followed");
   AST_DATA_HOLD:
      assert property (ok && (!read_tick_i || read_enable_n_i && !fall_through_mode_o)
         |=> $stable(read_data_o))
      else $error("output register changed without read");
   AST_FULL_ON_WRITE:
      assert property (ok && !write_tick_i |=> $stable(flags_o.full_ready_n))
      else $error("full flag moved off write edge");
   AST_EMPTY_ON_READ:
      assert property (ok && !read_tick_i |=> $stable(flags_o.empty_ready_n))
      else $error("empty flag moved off read edge");
   AST_ALMOST_FULL_SYNC:
      assert property (ok && !almost_async_i && !write_tick_i |=> $stable(flags_o.almost_full_n))
      else $error("sync almost-full moved off write edge");
   AST_HALF_ON_WRITE:
      assert property (ok && $fell(flags_o.half_full_n) |-> $past(write_tick_i))
      else $error("half-full fell without write");
   AST_READY_TRUE_READ:
      assert property (ok && fall_through_mode_o && $rose(flags_o.empty_ready_n)
         |-> $past(read_tick_i && !read_enable_n_i))
      else $error("output ready rose without true read");
   COV_FULL: cover property (ok && !flags_o.full_ready_n && !fall_through_mode_o);
   COV_FT_WORD: cover property (ok && fall_through_mode_o && $fell(flags_o.empty_ready_n));
   COV_HALF: cover property (ok && $fell(flags_o.half_full_n));
endmodule

bind dcf_fifo_top dcf_fifo_assertions #(.WIDTH(WIDTH)) i_dcf_fifo_assertions (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .fifo_reset_n_i(fifo_reset_n_i),
   .write_tick_i(write_tick_i), .read_tick_i(read_tick_i), .read_enable_n_i(read_enable_n_i),
   .output_enable_n_i(output_enable_n_i), .almost_async_i(almost_async_i),
   .read_data_o(read_data_o), .read_data_oe_o(read_data_oe_o), .flags_o(flags_o),
   .fall_through_mode_o(fall_through_mode_o));

/* File: dcf_fifo_top.sv */
// flagged fifo with standard and fall-through timing, offset load and readback
//
// Operation
// - reset pin low returns both pointers to the first location; reset before writing
// - full flag resets high standard, low fall-through; empty flag resets low standard, high fall-through
// - after reset half-full and almost-full read high, almost-empty reads low
// - reset zeroes the output register and restores both offset registers
// - write enable low and not full stores one word per write edge
// - write enable is ignored while the memory is full, in both modes
// - standard full flag low after 4096 writes, high after a read
// - fall-through input ready high after 4097 writes, low after a read
// - read enable low and not empty moves next word to output register
// - standard reads need read enable; empty flag low when drained
// - fall-through first word appears on third read edge without read enable
// - output ready high only on a true read after last word; data kept
// - empty/output-ready flag updates on the read edge
// - output enable low drives data outputs, high releases them
// - offset load and write enable low write empty then full offset, cycling
// - loading may stop after one register; sequence position is kept
// - offset load low and write enable high ignores the write edge
// - offset readback alternates with its own pointer, standard mode only
// - almost-full low at 4096 minus full offset, 4097 in fall-through
// - almost-full async: set on write, clear on read; sync: write edges
// - almost-empty low at or below empty offset, plus one fall-through
// - timing mode latched during reset from select and chain inputs
// - both offsets default to 127
// - half-full low after half filled, high again on read at half or less, plus one fall-through
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_fifo_top #(
   parameter int DEPTH       = `DCF_DEPTH,
   parameter int WIDTH       = `DCF_WIDTH,
   parameter int OFS_W       = `DCF_OFS_W,
   parameter int STAGE_DEPTH = `DCF_STAGE_DEPTH
) (
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   input  wire logic                fifo_reset_n_i,
   input  wire logic                first_device_select_n_i,
   input  wire logic                write_chain_in_n_i,
   input  wire logic                read_chain_in_n_i,
   input  wire logic                write_tick_i,
   input  wire logic                write_enable_n_i,
   input  wire logic [WIDTH-1:0]    write_data_i,
   input  wire logic                read_tick_i,
   input  wire logic                read_enable_n_i,
   input  wire logic                output_enable_n_i,
   input  wire logic                offset_load_n_i,
   input  wire logic                almost_async_i,
   output logic      [WIDTH-1:0]    read_data_o,
   output logic                     read_data_oe_o,
   output dcf_pkg::dcf_flags_t      flags_o,
   output logic                     fall_through_mode_o,
   output logic                     stage_ready_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk_depth
      $error("depth must be a power of two, at least 4");
   end
   if (OFS_W > WIDTH || OFS_W > AW) begin : g_chk_ofs
      $error("offset width must fit the data and the depth");
   end

   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);

   // pin synchroniser: reset pin and mode straps
   logic [`DCF_SYNC_BITS-1:0] sync_q1;
   logic [`DCF_SYNC_BITS-1:0] sync_q2;
   logic                      func_rst;
   logic                      mode_sel_fall_through_mode;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_q1 <= '0;
         sync_q2 <= '0;
      end else begin
         sync_q1 <= {read_chain_in_n_i, write_chain_in_n_i,
                     first_device_select_n_i, fifo_reset_n_i};
         sync_q2 <= sync_q1;
      end
   end

   assign func_rst      = ~sync_q2[`DCF_SYNC_RESET];
   assign mode_sel_fall_through_mode = sync_q2[`DCF_SYNC_FIRST] & ~sync_q2[`DCF_SYNC_WCHAIN]
                          & ~sync_q2[`DCF_SYNC_RCHAIN];

   // mode taken while reset is held
   dcf_pkg::dcf_mode_t mode;
   logic               fall_through_mode;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode <= dcf_pkg::DCF_MODE_STANDARD;
      end else if (func_rst) begin
         mode <= mode_sel_fall_through_mode ? dcf_pkg::DCF_MODE_FALL_THROUGH
                               : dcf_pkg::DCF_MODE_STANDARD;
      end
   end

   assign fall_through_mode = (mode == dcf_pkg::DCF_MODE_FALL_THROUGH);

   // storage, counters and stage buffer
   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0]    mem_wcnt;
   logic [CW-1:0]    mem_rcnt;
   logic [CW-1:0]    seen_q1;
   logic [CW-1:0]    seen_q2;
   logic [CW-1:0]    fill;
   logic [CW-1:0]    next_fill;
   logic [CW-1:0]    cap;
   logic [CW-1:0]    avail;
   logic [CW-1:0]    next_avail;
   logic [WIDTH-1:0] out_q;
   logic             out_valid;
   logic             next_out_valid;
   logic             stage_rdy;
   logic             stage_valid;
   logic [WIDTH-1:0] stage_data;
   logic             mem_room;
   logic             mem_push;
   logic [OFS_W-1:0] empty_ofs;
   logic [OFS_W-1:0] full_ofs;
   logic [OFS_W-1:0] ofs_value;

   // write and read decode
   logic wr_cycle;
   logic rd_cycle;
   logic full_now;
   logic wr_accept;
   logic ofs_wr;
   logic ofs_rd;
   logic std_read;
   logic fall_through_mode_take;
   logic fall_through_mode_load;
   logic mem_pop;
   logic consume;

   // in fall-through the output register adds one word of room
   assign cap      = fall_through_mode ? DEPTH_C + CW'(1) : DEPTH_C;
   assign full_now = fill >= cap;
   assign wr_cycle = write_tick_i & ~write_enable_n_i & ~func_rst;
   assign rd_cycle = read_tick_i & ~read_enable_n_i & ~func_rst;

   // offset load with write enable high does nothing
   assign ofs_wr = wr_cycle & ~offset_load_n_i;
   assign wr_accept = wr_cycle & offset_load_n_i & ~full_now & stage_rdy;
   assign ofs_rd = rd_cycle & ~offset_load_n_i & ~fall_through_mode;

   // standard read needs read enable and a stored word
   assign std_read  = rd_cycle & offset_load_n_i & ~fall_through_mode & (avail != '0);
   assign fall_through_mode_take = rd_cycle & offset_load_n_i & fall_through_mode & out_valid;
   assign fall_through_mode_load = read_tick_i & ~func_rst & fall_through_mode & offset_load_n_i
                      & (avail != '0) & (~out_valid | fall_through_mode_take);
   assign mem_pop   = std_read | fall_through_mode_load;
   assign consume   = std_read | fall_through_mode_take;

   assign mem_room = (mem_wcnt - mem_rcnt) < DEPTH_C;
   assign mem_push = stage_valid & mem_room & ~func_rst;
   assign avail    = seen_q2 - mem_rcnt;

   logic stage_rdy_q;
   assign stage_ready_o = stage_rdy_q;

   dcf_stage_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (STAGE_DEPTH)
   ) u_stage (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .clear_i     (func_rst),
      .in_valid_i  (wr_accept),
      .in_data_i   (write_data_i),
      .in_ready_o  (stage_rdy),
      .out_valid_o (stage_valid),
      .out_data_o  (stage_data),
      .out_ready_i (mem_room)
   );

   dcf_offset_regs #(
      .OFS_W (OFS_W)
   ) u_offsets (
      .core_clk_i     (core_clk_i),
      .rst_i          (rst_i),
      .clear_i        (func_rst),
      .load_i         (ofs_wr),
      .load_data_i    (write_data_i[OFS_W-1:0]),
      .read_i         (ofs_rd),
      .empty_offset_o (empty_ofs),
      .full_offset_o  (full_ofs),
      .read_value_o   (ofs_value)
   );

   always_ff @(posedge core_clk_i) begin
      if (mem_push) begin
         mem[mem_wcnt[AW-1:0]] <= stage_data;
      end
   end

   // pointers back to the first location
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_wcnt <= '0;
         mem_rcnt <= '0;
      end else if (func_rst) begin
         mem_wcnt <= '0;
         mem_rcnt <= '0;
      end else begin
         mem_wcnt <= mem_wcnt + CW'(mem_push);
         mem_rcnt <= mem_rcnt + CW'(mem_pop);
      end
   end

   // read side sees the write count two read edges late
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen_q1 <= '0;
         seen_q2 <= '0;
      end else if (func_rst) begin
         seen_q1 <= '0;
         seen_q2 <= '0;
      end else if (read_tick_i) begin
         seen_q1 <= mem_wcnt;
         seen_q2 <= seen_q1;
      end
   end

   assign next_fill      = fill + CW'(wr_accept) - CW'(consume);
   assign next_out_valid = fall_through_mode_load | (out_valid & ~fall_through_mode_take);
   assign next_avail     = seen_q1 - mem_rcnt - CW'(mem_pop);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fill <= '0;
      end else if (func_rst) begin
         fill <= '0;
      end else begin
         fill <= next_fill;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_q     <= '0;
         out_valid <= 1'b0;
      end else if (func_rst) begin
         out_q     <= '0;
         out_valid <= 1'b0;
      end else if (ofs_rd) begin
         out_q <= {{(WIDTH-OFS_W){1'b0}}, ofs_value};
      end else if (mem_pop) begin
         // next word into the output register
         out_q     <= mem[mem_rcnt[AW-1:0]];
         out_valid <= 1'b1;
      end else if (fall_through_mode_take) begin
         // last data stays on the outputs
         out_valid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_data_oe_o <= 1'b0;
      end else begin
         read_data_oe_o <= ~output_enable_n_i;
      end
   end

   assign read_data_o         = out_q;
   assign fall_through_mode_o = fall_through_mode;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage_rdy_q <= 1'b0;
      end else begin
         stage_rdy_q <= stage_rdy & ~func_rst;
      end
   end

   // flag conditions on the level after this cycle
   logic [CW-1:0] paf_level;
   logic [CW-1:0] pae_level;
   logic [CW-1:0] hf_level;
   logic          paf_cond;
   logic          pae_cond;
   logic          hf_cond;

   assign paf_level = cap - CW'(full_ofs);
   assign paf_cond  = next_fill >= paf_level;
   assign pae_level = CW'(empty_ofs) + CW'(fall_through_mode);
   assign pae_cond  = next_fill <= pae_level;
   assign hf_level  = HALF_C + CW'(fall_through_mode);
   assign hf_cond   = next_fill > hf_level;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o.full_ready_n <= 1'b1;
      end else if (func_rst) begin
         flags_o.full_ready_n <= ~mode_sel_fall_through_mode;
      end else if (write_tick_i) begin
         flags_o.full_ready_n <= fall_through_mode ? (next_fill >= cap) : (next_fill < cap);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o.empty_ready_n <= 1'b0;
      end else if (func_rst) begin
         flags_o.empty_ready_n <= mode_sel_fall_through_mode;
      end else if (read_tick_i) begin
         // standard: words left; fall-through: register holds one
         flags_o.empty_ready_n <= fall_through_mode ? ~next_out_valid : (next_avail != '0);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o.almost_full_n <= 1'b1;
      end else if (func_rst) begin
         flags_o.almost_full_n <= 1'b1;
      end else if (almost_async_i) begin
         if (write_tick_i && paf_cond) begin
            flags_o.almost_full_n <= 1'b0;
         end else if (read_tick_i && !paf_cond) begin
            flags_o.almost_full_n <= 1'b1;
         end
      end else if (write_tick_i) begin
         flags_o.almost_full_n <= ~paf_cond;
      end
   end

   // almost-empty: async low on read, high on write; sync on read edge
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o.almost_empty_n <= 1'b0;
      end else if (func_rst) begin
         flags_o.almost_empty_n <= 1'b0;
      end else if (almost_async_i) begin
         if (read_tick_i && pae_cond) begin
            flags_o.almost_empty_n <= 1'b0;
         end else if (write_tick_i && !pae_cond) begin
            flags_o.almost_empty_n <= 1'b1;
         end
      end else if (read_tick_i) begin
         flags_o.almost_empty_n <= ~pae_cond;
      end
   end

   // half-full set on write, cleared on read
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o.half_full_n <= 1'b1;
      end else if (func_rst) begin
         flags_o.half_full_n <= 1'b1;
      end else if (write_tick_i && hf_cond) begin
         flags_o.half_full_n <= 1'b0;
      end else if (read_tick_i && !hf_cond) begin
         flags_o.half_full_n <= 1'b1;
      end
   end
endmodule

/* File: dcf_offset_regs.sv */
// empty and full offset registers with independent load and readback sequence
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_offset_regs #(
   parameter int OFS_W = 12
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             clear_i,
   input  wire logic             load_i,
   input  wire logic [OFS_W-1:0] load_data_i,
   input  wire logic             read_i,
   output logic      [OFS_W-1:0] empty_offset_o,
   output logic      [OFS_W-1:0] full_offset_o,
   output logic      [OFS_W-1:0] read_value_o
);
   dcf_pkg::dcf_ofs_sel_t wr_sel;
   dcf_pkg::dcf_ofs_sel_t rd_sel;

   always_comb begin
      case (rd_sel)
         dcf_pkg::DCF_SEL_EMPTY: read_value_o = empty_offset_o;
         dcf_pkg::DCF_SEL_FULL:  read_value_o = full_offset_o;
         default:                read_value_o = empty_offset_o;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         empty_offset_o <= OFS_W'(`DCF_OFS_DEFAULT);
         full_offset_o  <= OFS_W'(`DCF_OFS_DEFAULT);
         wr_sel         <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (clear_i) begin
         empty_offset_o <= OFS_W'(`DCF_OFS_DEFAULT);
         full_offset_o  <= OFS_W'(`DCF_OFS_DEFAULT);
         wr_sel         <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (load_i) begin
         case (wr_sel)
            dcf_pkg::DCF_SEL_EMPTY: begin
               empty_offset_o <= load_data_i;
               wr_sel         <= dcf_pkg::DCF_SEL_FULL;
            end
            default: begin
               full_offset_o <= load_data_i;
               wr_sel        <= dcf_pkg::DCF_SEL_EMPTY;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_sel <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (clear_i) begin
         rd_sel <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (read_i) begin
         case (rd_sel)
            dcf_pkg::DCF_SEL_EMPTY: rd_sel <= dcf_pkg::DCF_SEL_FULL;
            default:                rd_sel <= dcf_pkg::DCF_SEL_EMPTY;
         endcase
      end
   end
endmodule

/* File: dcf_pkg.sv */
// types shared by the dual-port flagged fifo
package dcf_pkg;

   typedef enum logic {
      DCF_MODE_STANDARD,
      DCF_MODE_FALL_THROUGH
   } dcf_mode_t;

   typedef enum logic {
      DCF_SEL_EMPTY,
      DCF_SEL_FULL
   } dcf_ofs_sel_t;

   // all flags are active low as seen at the pins
   typedef struct packed {
      logic full_ready_n;
      logic empty_ready_n;
      logic almost_full_n;
      logic almost_empty_n;
      logic half_full_n;
   } dcf_flags_t;

endpackage

/* File: dcf_stage_fifo.sv */
// small valid/ready fifo in front of the main storage
`timescale 1ns/100ps
module dcf_stage_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             clear_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("stage depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] buf_q [DEPTH];
   logic [AW:0]      wr_idx;
   logic [AW:0]      rd_idx;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_idx - rd_idx) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_idx != rd_idx;
   assign out_data_o  = buf_q[rd_idx[AW-1:0]];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         buf_q[wr_idx[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_idx <= '0;
         rd_idx <= '0;
      end else if (clear_i) begin
         wr_idx <= '0;
         rd_idx <= '0;
      end else begin
         wr_idx <= wr_idx + (AW+1)'(push);
         rd_idx <= rd_idx + (AW+1)'(pop);
      end
   end
endmodule

/* File: testbench.sv */
// self-checking bench for the flagged fifo
`timescale 1ns/100ps
module testbench;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                res_n = 1'b0;
   logic                sel_n = 1'b0;
   logic                wt = 1'b0;
   logic                wen_n = 1'b1;
   logic [17:0]         wd = 18'h00000;
   logic                rt = 1'b0;
   logic                ren_n = 1'b1;
   logic                oen_n = 1'b0;
   logic                ld_n = 1'b1;
   logic                aa = 1'b0;
   logic                take = 1'b0;
   logic                take_d = 1'b0;
   logic [17:0]         q, bus_q, lastw;
   logic                oe, ft, sr;
   dcf_pkg::dcf_flags_t fl;
   logic [17:0]         expq[$];
   logic [31:0]         seed = 32'h7181;
   int                  fail_count = 0;
   int                  checks_done = 0;
   int                  n;
   always #10 clk = ~clk;
   dcf_fifo_top i_dcf_fifo_top (.core_clk_i(clk), .rst_i(rst), .fifo_reset_n_i(res_n),
      .first_device_select_n_i(sel_n), .write_chain_in_n_i(1'b0), .read_chain_in_n_i(1'b0),
      .write_tick_i(wt), .write_enable_n_i(wen_n), .write_data_i(wd), .read_tick_i(rt),
      .read_enable_n_i(ren_n), .output_enable_n_i(oen_n), .offset_load_n_i(ld_n),
      .almost_async_i(aa), .read_data_o(q), .read_data_oe_o(oe), .flags_o(fl),
      .fall_through_mode_o(ft), .stage_ready_o(sr));
   dcf_far_end i_dcf_far_end (.core_clk_i(clk), .q_i(q), .oe_i(oe), .bus_q_o(bus_q));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic good, input string m);
      checks_done++;
      if (good !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wr(input logic en_n, input logic [17:0] d);
      int w;
      w = 0;
      while (sr !== 1'b1 && w < 50) begin
         w++;
         cyc(1);
      end
      wt = 1'b1;
      wen_n = en_n;
      wd = d;
      cyc(1);
      wt = 1'b0;
      wen_n = 1'b1;
      cyc(1);
   endtask
   task automatic wr_rand(input logic keep);
      seed = lfsr(seed);
      if (keep) begin
         expq.push_back(seed[17:0]);
         lastw = seed[17:0];
      end
      wr(1'b0, seed[17:0]);
   endtask
   task automatic rd(input logic en_n, input logic t);
      rt = 1'b1;
      ren_n = en_n;
      take = t;
      cyc(1);
      rt = 1'b0;
      ren_n = 1'b1;
      take = 1'b0;
      cyc(1);
   endtask
   task automatic fifo_rst(input logic fall);
      res_n = 1'b0;
      sel_n = fall; // single device strap
      cyc(5);
      res_n = 1'b1;
      cyc(4);
   endtask
   always @(posedge clk) take_d <= take;
   always @(negedge clk) begin
      if (take_d && expq.size() == 0) begin
         chk(1'b0, "read with nothing expected");
      end else if (take_d) begin
         chk(bus_q === expq.pop_front(), "read data mismatch");
      end
   end
   initial begin
      #(40000 * 20);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      cyc(5);
      rst = 1'b0;
      fifo_rst(1'b0);
      chk(ft === 1'b0 && fl === 5'b10101 && q === 18'h0, "standard reset");
      // offsets are never read and written at once
      ld_n = 1'b0;
      rd(1'b0, 1'b0);
      chk(bus_q === 18'h0007f, "empty offset default");
      rd(1'b0, 1'b0);
      chk(bus_q === 18'h0007f, "full offset default");
      wr(1'b0, 18'h3f005);
      ld_n = 1'b1;
      cyc(1);
      ld_n = 1'b0;
      wr(1'b1, 18'h000aa);
      wr(1'b0, 18'h000c8);
      rd(1'b0, 1'b0);
      chk(bus_q === 18'h00005, "empty offset load");
      rd(1'b0, 1'b0);
      chk(bus_q === 18'h000c8, "full offset load");
      ld_n = 1'b1;
      for (int i = 1; i <= 4097; i++) begin
         wr_rand(i < 4097);
         if (i == 2048 || i == 2049 || i == 3895 || i == 3896) begin
            cyc(2);
            chk(fl.half_full_n === (i < 2049), "half fill");
            chk(fl.almost_full_n === (i < 3896), "almost full fill");
         end
      end
      // idle read edges let the read side see the write count
      repeat (2) rd(1'b1, 1'b0);
      chk(fl.full_ready_n === 1'b0 && fl.almost_empty_n === 1'b1, "full");
      rd(1'b0, 1'b1);
      repeat (3) wr(1'b1, 18'h00000);
      chk(fl.full_ready_n === 1'b1, "full cleared by read");
      aa = 1'b1;
      n = 0;
      while (fl.empty_ready_n === 1'b1 && n < 5000) begin
         rd(1'b0, 1'b1);
         n++;
         if (n == 199 || n == 200) begin
            chk(fl.almost_full_n === (n == 200), "async almost full on read");
         end
         if (n == 4089 || n == 4090) begin
            chk(fl.almost_empty_n === (n == 4089), "almost empty level");
         end
      end
      chk(n == 4095 && expq.size() == 0, "drain count");
      rd(1'b0, 1'b0);
      chk(bus_q === lastw, "read while empty ignored");
      oen_n = 1'b1;
      cyc(2);
      chk(oe === 1'b0, "outputs released");
      oen_n = 1'b0;
      fifo_rst(1'b1);
      chk(ft === 1'b1 && fl === 5'b01101 && q === 18'h0, "fall-through reset");
      ld_n = 1'b0;
      rd(1'b0, 1'b0);
      chk(bus_q === 18'h0, "offset readback blocked");
      ld_n = 1'b1;
      wr_rand(1'b1);
      cyc(2);
      n = 0;
      while (fl.empty_ready_n === 1'b1 && n < 8) begin
         rd(1'b1, n == 2);
         n++;
      end
      chk(n == 3, "first word on third read edge");
      rd(1'b0, 1'b0);
      chk(fl.empty_ready_n === 1'b1 && bus_q === lastw, "ready after true read");
      end_sim();
   end
endmodule
